// file: rtl/isr_pkg.sv
package isr_pkg;

  // fixed upper five bits of the 7-bit slave address (binary 01010)
  localparam logic [4:0] ISR_ADDR_FIXED = 5'h0A;
  // register address that selects the FIFO port instead of the register store
  localparam logic [7:0] ISR_FIFO_ADDR  = 8'h05;
  // register pointer value after reset
  localparam logic [7:0] ISR_PTR_RESET  = 8'h00;
  // byte returned when a FIFO-address read finds no byte waiting
  localparam logic [7:0] ISR_IDLE_BYTE  = 8'h00;
  // bit counter positions: last data bit and the acknowledge slot
  localparam logic [3:0] ISR_LAST_BIT   = 4'h7;
  localparam logic [3:0] ISR_ACK_SLOT   = 4'h8;
  localparam logic [3:0] ISR_CNT_RESET  = 4'h0;
  // widths and depths used as module parameter defaults
  localparam int ISR_DATA_W     = 8;
  localparam int ISR_FIFO_DEPTH = 16;
  localparam int ISR_REG_AW     = 8;
  // link rate ceiling and the clock rate, both in kHz
  localparam int ISR_LINK_MAX_KHZ = 5000;
  localparam int ISR_CLK_KHZ      = 40000;
  // fewest clock cycles in one half of the fastest legal scl period
  localparam int ISR_MIN_HALF_CYC = ISR_CLK_KHZ / (2 * ISR_LINK_MAX_KHZ);

  // transfer phase of the slave
  typedef enum logic [2:0] {
    ST_IDLE,   // bus free
    ST_ADDR,   // shifting the address byte
    ST_REG,    // shifting the register address byte
    ST_WRITE,  // shifting data bytes to store
    ST_READ,   // sending data bytes
    ST_SKIP    // not selected or read ended, wait for start or stop
  } isr_state_type;

  // sampled levels of the two link lines
  typedef struct packed {
    logic scl;
    logic sda;
  } isr_line_type;

  // one driver on the data line
  typedef struct packed {
    logic out;
    logic oe;
  } isr_drive_type;

  // one register store write
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } isr_write_type;

endpackage

// file: rtl/isr_fifo.sv
`timescale 1ns/10ps
module isr_fifo
  import isr_pkg::*;
#(
  parameter int WIDTH = ISR_DATA_W,
  parameter int DEPTH = ISR_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];   // storage words
  logic [AW-1:0]    wr_ptr;        // next word to fill
  logic [AW-1:0]    rd_ptr;        // next word to drain
  logic [AW:0]      count;         // words held
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             do_push;
  logic             do_pop;

  // full and empty come straight from the count, so they never lie
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign do_push   = in_valid & in_ready;
  assign do_pop    = out_valid & out_ready;

  // pointer and count update
  always_comb begin
    next_wr_ptr = do_push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = do_pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count  = count + (AW+1)'(do_push) - (AW+1)'(do_pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // storage carries no reset; only written words are ever read
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule // isr_fifo

// file: rtl/isr_regmem.sv
`timescale 1ns/10ps
module isr_regmem
  import isr_pkg::*;
#(
  parameter int AW = ISR_REG_AW,
  parameter int DW = ISR_DATA_W
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // read port, data one cycle after the address
  input  wire logic [AW-1:0] raddr,
  output logic [DW-1:0]      rdata
);
  logic [DW-1:0] mem [2**AW];   // register store
  logic [DW-1:0] next_rdata;

  // read data are registered; the caller has many cycles per scl bit
  always_comb begin
    next_rdata = mem[raddr];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end

  // array write
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

endmodule // isr_regmem

// file: rtl/isr_slave.sv
// Behaviour
// - sda changes only while scl low
// - sda fall with scl high starts frame
// - sda rise with scl high ends frame
// - repeated start handled like plain start
// - bytes msb first, then acknowledge bit
// - receiver holds sda low in acknowledge
// - master nack ends read, slave releases
// - address 01010 plus two selectable bits
// - first byte after start is address
// - write frame: address, register, data bytes
// - fifo address: all data into fifo
// - read returns previously addressed register
// - read pointer increments except for fifo
// - slave never stretches the clock
// - keeper holds sda while scl high
// - push-pull pin address forces high bit 0
// - push-pull drivers only while scl low
// - general call ignored, no device id
`timescale 1ns/10ps
module isr_slave
  import isr_pkg::*;
#(
  parameter int FIFO_DEPTH = ISR_FIFO_DEPTH,
  parameter int REG_AW     = ISR_REG_AW
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_b,
  // link lines
  input  wire isr_line_type  bus_in,
  output isr_drive_type      sda_drv,
  output isr_drive_type      keeper,
  // configuration
  input  wire logic          push_pull_point_link,
  input  wire logic [1:0]    adr_pins,
  input  wire logic [1:0]    adr_nv,
  input  wire logic          adr_from_nv,
  // status
  output logic               bus_busy,
  // register store writes seen by the core
  output isr_write_type      reg_wr,
  output logic               reg_wr_valid,
  // bytes written to the fifo address, drained by the core
  output logic [7:0]         fifo_data,
  output logic               fifo_valid,
  input  wire logic          fifo_ready,
  // bytes the core offers for reads at the fifo address
  input  wire logic [7:0]    tx_data,
  input  wire logic          tx_valid,
  output logic               tx_ready
);

  logic [1:0]    rst_sync;       // reset release chain
  logic          rst_n;          // synchronised reset, active low
  isr_line_type  bus_q;          // previous sample of the lines
  isr_state_type state;          // transfer phase
  logic [3:0]    cnt;            // bit index, 8 is the acknowledge slot
  logic [7:0]    shift;          // received byte
  logic [7:0]    tx;             // bits still to send
  logic [7:0]    ptr;            // register pointer
  logic          drv_en;         // slave wants the data line
  logic          drv_bit;        // level the slave wants
  logic          keep;           // last level seen while scl low
  isr_state_type next_state;
  logic [3:0]    next_cnt;
  logic [7:0]    next_shift;
  logic [7:0]    next_tx;
  logic [7:0]    next_ptr;
  logic          next_drv_en;
  logic          next_drv_bit;
  logic          next_keep;
  logic          next_reg_wr_valid;
  isr_write_type next_reg_wr;
  logic          scl_rise;       // scl edge seen this cycle
  logic          scl_fall;
  logic          start_det;      // start or repeated start
  logic          stop_det;
  logic [1:0]    sel_bits;       // selectable address bits
  logic          addr_hit;       // address byte names this slave
  logic          push;           // byte into the fifo
  logic          push_ready;     // fifo has room
  logic          mem_we;         // byte into the register store
  logic [7:0]    mem_rdata;      // register at the pointer
  logic [7:0]    rd_byte;        // byte about to be sent

  // reset is asserted at once and released through two flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // edge and condition detection against the previous sample
  assign scl_rise  = bus_in.scl & ~bus_q.scl;
  assign scl_fall  = ~bus_in.scl & bus_q.scl;
  assign start_det = bus_in.scl & bus_q.scl & bus_q.sda & ~bus_in.sda;
  assign stop_det  = bus_in.scl & bus_q.scl & ~bus_q.sda & bus_in.sda;

  // pin strap loses its high bit on the push-pull link
  assign sel_bits = adr_from_nv ? adr_nv :
                    (push_pull_point_link ? {1'b0, adr_pins[0]} : adr_pins);
  // fixed bits are nonzero, so the general call address never matches
  assign addr_hit = (shift[7:1] == {ISR_ADDR_FIXED, sel_bits});

  // fifo address reads take the core's byte, or a filler when none waits
  assign rd_byte  = (ptr == ISR_FIFO_ADDR) ? (tx_valid ? tx_data : ISR_IDLE_BYTE) :
                    mem_rdata;

  // bit engine: sample on scl rise, act and change sda on scl fall
  always_comb begin
    next_state        = state;
    next_cnt          = cnt;
    next_shift        = shift;
    next_tx           = tx;
    next_ptr          = ptr;
    next_drv_en       = drv_en;
    next_drv_bit      = drv_bit;
    next_keep         = keep;
    next_reg_wr       = reg_wr;
    next_reg_wr_valid = 1'b0;
    push              = 1'b0;
    mem_we            = 1'b0;
    tx_ready          = 1'b0;
    // keeper follows the line only while scl is low
    if (!bus_in.scl) begin
      next_keep = bus_in.sda;
    end
    if (start_det) begin
      // any start restarts the address phase and drops our driver
      next_state  = ST_ADDR;
      // the master's next scl fall ends no bit: parking in the acknowledge
      // slot lets that fall clear the count, so the address takes 8 bits
      next_cnt    = ISR_ACK_SLOT;
      next_drv_en = 1'b0;
    end else if (stop_det) begin
      next_state  = ST_IDLE;
      next_cnt    = ISR_CNT_RESET;
      next_drv_en = 1'b0;
    end else if (state != ST_IDLE && state != ST_SKIP) begin
      if (scl_rise) begin
        if (cnt != ISR_ACK_SLOT) begin
          next_shift = {shift[6:0], bus_in.sda};
        end else if (state == ST_READ && bus_in.sda) begin
          // master withheld the acknowledge: stay off the line
          next_state  = ST_SKIP;
          next_drv_en = 1'b0;
        end
      end else if (scl_fall) begin
        if (cnt == ISR_LAST_BIT) begin
          // byte complete: prepare the acknowledge slot
          next_cnt     = ISR_ACK_SLOT;
          next_drv_en  = 1'b1;
          next_drv_bit = 1'b0;
          unique case (state)
            ST_ADDR: begin
              if (!addr_hit) begin
                next_state  = ST_SKIP;
                next_drv_en = 1'b0;
              end else if (shift[0]) begin
                next_state = ST_READ;
              end else begin
                next_state = ST_REG;
              end
            end
            ST_REG: begin
              next_ptr   = shift;
              next_state = ST_WRITE;
            end
            ST_WRITE: begin
              if (ptr == ISR_FIFO_ADDR) begin
                // a full fifo refuses the byte with a nack
                push        = push_ready;
                next_drv_en = push_ready;
              end else begin
                mem_we            = 1'b1;
                next_ptr          = ptr + 8'h01;
                next_reg_wr       = '{addr: ptr, data: shift};
                next_reg_wr_valid = 1'b1;
              end
            end
            ST_READ: begin
              next_drv_en = 1'b0;
            end
            ST_IDLE, ST_SKIP: begin
              next_drv_en = 1'b0;
            end
          endcase
        end else if (cnt == ISR_ACK_SLOT) begin
          next_cnt    = ISR_CNT_RESET;
          next_drv_en = 1'b0;
          if (state == ST_READ) begin
            // load the next byte and put its msb out
            next_drv_en  = 1'b1;
            next_drv_bit = rd_byte[7];
            next_tx      = {rd_byte[6:0], 1'b0};
            if (ptr == ISR_FIFO_ADDR) begin
              tx_ready = tx_valid;
            end else begin
              next_ptr = ptr + 8'h01;
            end
          end
        end else begin
          next_cnt = cnt + 4'h1;
          if (state == ST_READ) begin
            next_drv_bit = tx[7];
            next_tx      = {tx[6:0], 1'b0};
          end
        end
      end
    end
  end

  // engine registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_q        <= '{scl: 1'b1, sda: 1'b1};
      state        <= ST_IDLE;
      cnt          <= ISR_CNT_RESET;
      shift        <= 8'h00;
      tx           <= 8'h00;
      ptr          <= ISR_PTR_RESET;
      drv_en       <= 1'b0;
      drv_bit      <= 1'b1;
      keep         <= 1'b1;
      reg_wr       <= '0;
      reg_wr_valid <= 1'b0;
    end else begin
      bus_q        <= bus_in;
      state        <= next_state;
      cnt          <= next_cnt;
      shift        <= next_shift;
      tx           <= next_tx;
      ptr          <= next_ptr;
      drv_en       <= next_drv_en;
      drv_bit      <= next_drv_bit;
      keep         <= next_keep;
      reg_wr       <= next_reg_wr;
      reg_wr_valid <= next_reg_wr_valid;
    end
  end

  // sda driver: open drain pulls low only; push-pull lets go the moment scl
  // rises, which is why the enable is gated by the raw scl input
  always_comb begin
    if (push_pull_point_link) begin
      sda_drv.oe  = drv_en & ~bus_in.scl;
      sda_drv.out = drv_bit;
    end else begin
      sda_drv.oe  = drv_en & ~drv_bit;
      sda_drv.out = 1'b0;
    end
  end
  // there is no scl output at all, so the clock can never be held low

  // keeper holds the last level through the high phase when nobody drives
  assign keeper.oe  = push_pull_point_link & bus_in.scl & ~sda_drv.oe &
                      (state != ST_IDLE);
  assign keeper.out = keep;
  assign bus_busy   = (state != ST_IDLE);

  isr_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (push_ready),
    .in_data   (shift),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .out_data  (fifo_data)
  );

  isr_regmem #(
    .AW (REG_AW),
    .DW (8)
  ) u_regmem (
    .clk   (clk),
    .rst_n (rst_n),
    .we    (mem_we),
    .waddr (ptr[REG_AW-1:0]),
    .wdata (shift),
    .raddr (ptr[REG_AW-1:0]),
    .rdata (mem_rdata)
  );

  // checks on the engine
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_start_to_addr: assert property (start_det |=> state == ST_ADDR && cnt == ISR_ACK_SLOT)
    else $error("start did not enter the address phase");
  a_stop_to_idle: assert property (stop_det && !start_det |=> state == ST_IDLE)
    else $error("stop did not free the bus");
  a_pp_high_free: assert property (push_pull_point_link && bus_in.scl |-> !sda_drv.oe)
    else $error("push-pull driver on while scl high");
  a_keeper_level: assert property (push_pull_point_link && scl_rise
                                   |=> keep == $past(bus_in.sda))
    else $error("keeper lost the level at scl rise");
  a_addr_ack: assert property (state == ST_ADDR && scl_fall && cnt == 4'h7 && addr_hit
                               |=> drv_en && !drv_bit && cnt == 4'h8)
    else $error("matched address not acknowledged");
  a_skip_silent: assert property (state == ST_SKIP |-> !drv_en)
    else $error("unselected slave drives sda");
  a_nack_release: assert property (state == ST_READ && scl_rise && cnt == 4'h8 && bus_in.sda
                                   |=> state == ST_SKIP ##1 !sda_drv.oe)
    else $error("slave kept sda after master nack");
  a_msb_first: assert property (state == ST_READ && scl_fall && cnt < 4'h7
                                |=> drv_bit == $past(tx[7]))
    else $error("read bit out of order");
  a_fifo_fixed: assert property (push |=> ptr == ISR_FIFO_ADDR)
    else $error("fifo write moved the pointer");
  a_write_inc: assert property (mem_we |=> ptr == $past(ptr) + 8'h01)
    else $error("write did not advance the pointer");
  a_read_inc: assert property (state == ST_READ && scl_fall && cnt == 4'h8
                               && ptr != ISR_FIFO_ADDR |=> ptr == $past(ptr) + 8'h01)
    else $error("read did not advance the pointer");
  a_pin_high_bit: assert property (push_pull_point_link && !adr_from_nv |-> !sel_bits[1])
    else $error("pin address high bit not zero");
  a_change_low: assert property (($changed(drv_en) || $changed(drv_bit))
                                 && !$past(start_det) && !$past(stop_det) |-> !bus_q.scl)
    else $error("slave changed sda while scl high");

  c_write_ack: cover property (state == ST_WRITE && mem_we);
  c_fifo_push: cover property (push);
  c_read_byte: cover property (state == ST_READ && tx_ready);
  c_read_nack: cover property (state == ST_READ ##1 state == ST_SKIP);

endmodule // isr_slave

// file: dv/isr_host_model.sv
`timescale 1ns/10ps
module isr_host_model (
  // clock and link mode
  input  wire logic clk,
  input  wire logic push_pull,
  // resolved data line
  input  wire logic sda_in,
  // master drivers
  output logic      scl,
  output logic      sda_out,
  output logic      sda_oe
);
  // idle link: clock high, data released high
  initial begin
    scl     = 1'h1;
    sda_out = 1'h1;
    sda_oe  = 1'h0;
  end

  // let n edges pass, then act just after the last one
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // open drain only ever pulls low; push-pull drives both levels
  task automatic put(input logic b);
    sda_out = push_pull ? b : 1'h0;
    sda_oe  = push_pull | !b;
  endtask

  // clock high; push-pull hands the data line to the keeper
  task automatic rise();
    scl = 1'h1;
    if (push_pull) sda_oe = 1'h0;
  endtask

  // start or repeated start, ends with clock low; the host keeps sda driven
  // through the high phase, since nobody else holds the line before a frame
  task automatic start();
    wt(3); // lets the slave's last drive end first
    put(1'h1);
    wt(5);
    scl = 1'h1;
    wt(5);
    put(1'h0);
    wt(5);
    scl = 1'h0;
  endtask

  // stop, leaves the line idle and high
  task automatic stop();
    wt(3);
    put(1'h0);
    wt(2);
    rise();
    wt(5);
    put(1'h1);
    wt(5);
  endtask

  // one bit, 5 cycles per half keeps the rate at 4 MHz
  task automatic bit_io(input logic b, input logic drv, output logic r);
    wt(3); // waits out the slave's release so drivers never overlap
    if (drv) put(b);
    else sda_oe = 1'h0;
    wt(2);
    rise();
    wt(2);
    r = sda_in;
    wt(3);
    scl = 1'h0;
  endtask

  // byte out msb first, then sample the acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], 1'h1, r);
    bit_io(1'h1, 1'h0, r);
    ack = !r;
  endtask

  // byte in msb first; last byte is not acknowledged
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, 1'h0, r);
      d[i] = r;
    end
    bit_io(last, 1'h1, r);
  endtask
endmodule // isr_host_model

// file: dv/isr_slave_test.sv
`timescale 1ns/10ps
module isr_slave_test
  import isr_pkg::*;
();
  // clock, reset and configuration
  logic          clk         = 1'h0;
  logic          rst_b       = 1'h0;
  logic          pp          = 1'h0;
  logic [1:0]    adr_pins    = 2'h3;
  logic [1:0]    adr_nv      = 2'h2;
  logic          adr_from_nv = 1'h0;
  logic          fifo_ready  = 1'h0;
  logic [7:0]    tx_data     = 8'h81;
  logic          tx_valid    = 1'h0;
  // host drivers and resolved line
  logic          h_scl;
  logic          h_out;
  logic          h_oe;
  logic          sda_line;
  logic          sda_last    = 1'h1;
  isr_line_type  bus_in;
  // design outputs
  isr_drive_type sda_drv;
  isr_drive_type keeper;
  isr_write_type reg_wr;
  logic          bus_busy;
  logic          reg_wr_valid;
  logic          fifo_valid;
  logic          tx_ready;
  logic [7:0]    fifo_data;
  // captured traffic and bookkeeping
  isr_write_type wq[$];
  logic [7:0]    fq[$];
  int            tx_n        = 0;
  int            errors      = 0;
  int            checks      = 0;
  logic          ack;
  logic [7:0]    rd;

  always #12.5 clk = ~clk;

  // open drain pulls up; push-pull falls back to the keeper, else wanders
  always_comb begin
    if (!pp) sda_line = !((h_oe && !h_out) || (sda_drv.oe && !sda_drv.out));
    else if (h_oe) sda_line = h_out;
    else if (sda_drv.oe) sda_line = sda_drv.out;
    else if (keeper.oe) sda_line = keeper.out;
    else sda_line = !sda_last;
  end
  assign bus_in = '{scl: h_scl, sda: sda_line};

  isr_host_model u_host (.clk(clk), .push_pull(pp), .sda_in(sda_line), .scl(h_scl),
                         .sda_out(h_out), .sda_oe(h_oe));
  isr_slave u_dut (.clk(clk), .rst_b(rst_b), .bus_in(bus_in), .sda_drv(sda_drv),
                   .keeper(keeper), .push_pull_point_link(pp), .adr_pins(adr_pins),
                   .adr_nv(adr_nv), .adr_from_nv(adr_from_nv), .bus_busy(bus_busy),
                   .reg_wr(reg_wr), .reg_wr_valid(reg_wr_valid), .fifo_data(fifo_data),
                   .fifo_valid(fifo_valid), .fifo_ready(fifo_ready), .tx_data(tx_data),
                   .tx_valid(tx_valid), .tx_ready(tx_ready));

  task automatic fail(input string msg);
    errors++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checks++;
    if (got !== exp) fail(msg);
  endtask

  // capture pulses; on the push-pull link the slave must never drive while the clock is high
  always @(posedge clk) begin
    sda_last <= sda_line;
    if (reg_wr_valid === 1'h1) wq.push_back(reg_wr);
    if (fifo_valid === 1'h1 && fifo_ready) fq.push_back(fifo_data);
    if (tx_ready === 1'h1) tx_n++;
    if (pp && h_scl && sda_drv.oe !== 1'h0) fail("slave drives with clock high");
  end

  function automatic logic [7:0] dev(input logic [1:0] sel, input logic rd_n);
    return {ISR_ADDR_FIXED, sel, rd_n};
  endfunction

  // start, address for write, register byte
  task automatic point(input logic [7:0] a, input logic [7:0] r);
    u_host.start();
    u_host.wbyte(a, ack);
    chk(ack, 16'h1, "address not acknowledged");
    u_host.wbyte(r, ack);
    chk(ack, 16'h1, "register byte refused");
  endtask

  task automatic t_write();
    point(dev(2'h3, 1'h0), 8'h10);
    chk(bus_busy, 16'h1, "bus idle inside frame");
    u_host.wbyte(8'hA5, ack);
    chk(ack, 16'h1, "data byte refused");
    u_host.wbyte(8'h3C, ack);
    u_host.stop();
    chk(bus_busy, 16'h0, "bus busy after stop");
    chk(16'(wq.size()), 16'h2, "store write count");
    chk(wq.pop_front(), 16'h10A5, "first store write");
    chk(wq.pop_front(), 16'h113C, "second store write");
  endtask

  task automatic t_read();
    point(dev(2'h3, 1'h0), 8'h10);
    u_host.start();
    u_host.wbyte(dev(2'h3, 1'h1), ack);
    chk(ack, 16'h1, "read address refused");
    u_host.rbyte(1'h0, rd);
    chk(rd, 16'hA5, "first read byte");
    u_host.rbyte(1'h1, rd);
    chk(rd, 16'h3C, "second read byte");
    u_host.stop();
    chk(bus_busy, 16'h0, "line held after final byte");
  endtask

  // fill until refused with the drain stalled, then drain to empty
  task automatic t_fifo();
    point(dev(2'h3, 1'h0), ISR_FIFO_ADDR);
    for (int i = 0; i < 17; i++) begin
      u_host.wbyte(8'hC0 + 8'(i), ack);
      chk(ack, 16'(i < 16), "fifo fill acknowledge");
    end
    u_host.stop();
    chk(16'(wq.size()), 16'h0, "fifo byte reached store");
    fifo_ready = 1'h1;
    repeat (40) @(posedge clk);
    #1 fifo_ready = 1'h0;
    chk(16'(fq.size()), 16'h10, "fifo drain count");
    for (int i = 0; i < 16; i++) chk(fq.pop_front(), 16'hC0 + 16'(i), "fifo order");
    chk(fifo_valid, 16'h0, "fifo not empty");
  endtask

  task automatic t_txread();
    tx_valid = 1'h1;
    point(dev(2'h3, 1'h0), ISR_FIFO_ADDR);
    u_host.start();
    u_host.wbyte(dev(2'h3, 1'h1), ack);
    u_host.rbyte(1'h0, rd);
    chk(rd, 16'h81, "first fifo read");
    u_host.rbyte(1'h1, rd);
    chk(rd, 16'h81, "repeated fifo read");
    u_host.stop();
    tx_valid = 1'h0;
    chk(16'(tx_n), 16'h2, "bytes taken from source");
    u_host.start();
    u_host.wbyte(dev(2'h3, 1'h1), ack);
    u_host.rbyte(1'h1, rd);
    u_host.stop();
    chk(rd, 16'(ISR_IDLE_BYTE), "empty fifo read");
  endtask

  task automatic t_refuse();
    u_host.start();
    u_host.wbyte(dev(2'h1, 1'h0), ack);
    chk(ack, 16'h0, "foreign address acknowledged");
    u_host.wbyte(8'h10, ack);
    u_host.wbyte(8'h55, ack);
    chk(ack, 16'h0, "ignored frame acknowledged");
    u_host.start();
    u_host.wbyte(8'h00, ack);
    chk(ack, 16'h0, "general call acknowledged");
    u_host.stop();
    chk(16'(wq.size()), 16'h0, "ignored frame stored");
  endtask

  task automatic t_push();
    pp = 1'h1;
    u_host.put(1'h1);
    u_host.start();
    u_host.wbyte(dev(2'h3, 1'h0), ack);
    chk(ack, 16'h0, "pin high bit not forced");
    u_host.stop();
    point(dev(2'h1, 1'h0), 8'h20);
    u_host.wbyte(8'h77, ack);
    u_host.stop();
    adr_from_nv = 1'h1;
    point(dev(2'h2, 1'h0), 8'h20);
    u_host.start();
    u_host.wbyte(dev(2'h2, 1'h1), ack);
    u_host.rbyte(1'h1, rd);
    u_host.stop();
    chk(rd, 16'h77, "keeper lost read data");
    chk(wq.pop_front(), 16'h2077, "push-pull store write");
  endtask

  task automatic finish_test();
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // reset, then the scenarios in turn
  initial begin
    repeat (10) @(posedge clk);
    #1 rst_b = 1'h1;
    repeat (4) @(posedge clk);
    #1;
    t_write();
    t_read();
    t_fifo();
    t_txread();
    t_refuse();
    t_push();
    finish_test();
  end

  // the run needs under 10000 cycles
  initial begin
    repeat (30000) @(posedge clk);
    fail("watchdog expired");
    finish_test();
  end
endmodule // isr_slave_test
